// ==== src/cfp_regs.svh ====
// Offsets, field values, status codes and timing counts of the control frame parser.
`ifndef CFP_REGS_SVH
`define CFP_REGS_SVH

`define CFP_SYNC_HI      8'hA1
`define CFP_SYNC_LO      8'hEC
`define CFP_OFS_SYNC     6'h00
`define CFP_OFS_SYNC_LO  6'h01
`define CFP_OFS_REV      6'h02
`define CFP_OFS_CMD      6'h03
`define CFP_OFS_LEN      6'h08
`define CFP_OFS_LEN_END  6'h0B
`define CFP_OFS_ADDR     6'h0C
`define CFP_OFS_ADDR_END 6'h0D
`define CFP_CRC_LAST     6'h3D
`define CFP_OFS_HCRC     6'h3E
`define CFP_HDR_LAST     6'h3F

`define CFP_FRAME_REV    8'h03
`define CFP_CMD_READ     8'h03
`define CFP_CMD_WRITE    8'h04
`define CFP_CMD_RESET    8'h05
`define CFP_CMD_ALIVE    8'h0A

`define CFP_ST_OK        8'h00
`define CFP_ST_HCRC_BAD  8'hFB
`define CFP_ST_LEN_ZERO  8'hFD
`define CFP_ST_UNKNOWN   8'hFF

`define CFP_CRC_POLY     16'h1021
`define CFP_CRC_INIT     16'h0000

`define CFP_NUM_CONN     5
`define CFP_CONN_W       3
`define CFP_IDLE_S       10
`define CFP_CLK_HZ       50000000
`define CFP_GATEWAY_IDX  16'h0100

`endif

// ==== src/cfp_pkg.sv ====
// Types shared by the control frame parser modules.
package cfp_pkg;

  typedef struct packed {
    logic [2:0] conn;
    logic [7:0] data;
  } cfp_rx_byte_t;

  typedef struct packed {
    logic [2:0]  conn;
    logic [7:0]  status;
    logic [7:0]  opcode;
    logic [15:0] first_reg_index;
    logic [30:0] reg_count;
  } cfp_resp_t;

endpackage

// ==== src/cfp_crc16.sv ====
// One byte step of the header checksum, most significant bit first.
`timescale 1ns/1ps
`include "cfp_regs.svh"
module cfp_crc16
  import cfp_pkg::*;
(
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc_out
);

  always_comb
  begin
    logic [15:0] c;
    c = crc_in ^ {data, 8'h00};
    for (int b = 0; b < 8; b++)
    begin
      if (c[15])
        c = {c[14:0], 1'b0} ^ `CFP_CRC_POLY;
      else
        c = {c[14:0], 1'b0};
    end
    crc_out = c;
  end

endmodule

// ==== src/cfp_parser.sv ====
// Command frame header parser serving several control connections.
`timescale 1ns/1ps
`include "cfp_regs.svh"
module cfp_parser
  import cfp_pkg::*;
#(
  parameter int          NUM_CONN    = `CFP_NUM_CONN,
  parameter logic [31:0] IDLE_CYCLES = 32'(`CFP_IDLE_S * `CFP_CLK_HZ),
  parameter logic [15:0] GATEWAY_IDX = `CFP_GATEWAY_IDX
)
(
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic [NUM_CONN-1:0] conn_open,
  output logic      [NUM_CONN-1:0] conn_close,
  output logic      [NUM_CONN-1:0] conn_active,
  input  wire logic                rx_valid,
  output logic                     rx_ready,
  input  wire cfp_rx_byte_t        rx_byte,
  output logic                     resp_valid,
  input  wire logic                resp_ready,
  output cfp_resp_t                resp,
  output logic                     dev_restart,
  output logic                     net_cfg_apply
);

  // ------------------------------------------------------------
  // Reset synchroniser.
  // ------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // Per connection header state.
  // ------------------------------------------------------------
  logic [5:0]          pos_r    [NUM_CONN];
  logic [15:0]         crc_r    [NUM_CONN];
  logic [7:0]          rev_r    [NUM_CONN];
  logic [7:0]          cmd_r    [NUM_CONN];
  logic [31:0]         len_r    [NUM_CONN];
  logic [15:0]         addr_r   [NUM_CONN];
  logic [7:0]          hcrc_r   [NUM_CONN];
  logic [NUM_CONN-1:0] open_r;
  logic [NUM_CONN-1:0] timeout;
  logic                resp_valid_r;
  cfp_resp_t           resp_r;
  logic                restart_r;
  logic                apply_r;
  logic [NUM_CONN-1:0] close_r;

  logic [2:0]  c;
  logic [7:0]  d;
  logic [5:0]  pos;
  logic        accept;
  logic        hdr_done;
  logic [15:0] crc_seed;
  logic [15:0] crc_nxt;
  logic [15:0] hcrc_rx;
  logic [7:0]  status_nxt;
  logic        cmd_known;

  assign c        = rx_byte.conn;
  assign d        = rx_byte.data;
  assign rx_ready = rst_n_r && !resp_valid_r;
  assign accept   = rx_valid && rx_ready && (32'(c) < NUM_CONN) && open_r[c] && !timeout[c] &&
                    !conn_open[c];
  assign pos      = (32'(c) < NUM_CONN) ? pos_r[c] : 6'h00;
  assign hdr_done = accept && (pos == `CFP_HDR_LAST);
  assign crc_seed = (pos == `CFP_OFS_REV) ? `CFP_CRC_INIT : crc_r[c];
  assign hcrc_rx  = {hcrc_r[c], d};

  cfp_crc16 u_crc
  (
    .crc_in  (crc_seed),
    .data    (d),
    .crc_out (crc_nxt)
  );

  // ------------------------------------------------------------
  // Byte position, field assembly and running checksum.
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NUM_CONN; i++)
      begin
        pos_r[i]  <= 6'h00;
        crc_r[i]  <= `CFP_CRC_INIT;
        rev_r[i]  <= 8'h00;
        cmd_r[i]  <= 8'h00;
        len_r[i]  <= 32'h00000000;
        addr_r[i] <= 16'h0000;
        hcrc_r[i] <= 8'h00;
      end
    end
    else if (!rst_n_r)
    begin
      for (int i = 0; i < NUM_CONN; i++)
        pos_r[i] <= 6'h00;
    end
    else
    begin
      for (int i = 0; i < NUM_CONN; i++)
      begin
        if (conn_open[i] || timeout[i])
          pos_r[i] <= 6'h00;
      end
      if (accept && !conn_open[c])
      begin
        if (pos == `CFP_OFS_SYNC)
          pos_r[c] <= (d == `CFP_SYNC_HI) ? 6'h01 : 6'h00;
        else if (pos == `CFP_OFS_SYNC_LO)
          pos_r[c] <= (d == `CFP_SYNC_LO) ? 6'h02 : ((d == `CFP_SYNC_HI) ? 6'h01 : 6'h00);
        else
          pos_r[c] <= pos + 6'h01;
        if (pos >= `CFP_OFS_REV && pos <= `CFP_CRC_LAST)
          crc_r[c] <= crc_nxt;
        if (pos == `CFP_OFS_REV)
          rev_r[c] <= d;
        if (pos == `CFP_OFS_CMD)
          cmd_r[c] <= d;
        if (pos >= `CFP_OFS_LEN && pos <= `CFP_OFS_LEN_END)
          len_r[c] <= {len_r[c][23:0], d};
        if (pos >= `CFP_OFS_ADDR && pos <= `CFP_OFS_ADDR_END)
          addr_r[c] <= {addr_r[c][7:0], d};
        if (pos == `CFP_OFS_HCRC)
          hcrc_r[c] <= d;
      end
    end
  end

  // ------------------------------------------------------------
  // Header verdict.
  // ------------------------------------------------------------
  always_comb
  begin
    cmd_known = (cmd_r[c] == `CFP_CMD_READ) || (cmd_r[c] == `CFP_CMD_WRITE) ||
                (cmd_r[c] == `CFP_CMD_RESET) || (cmd_r[c] == `CFP_CMD_ALIVE);
    if (hcrc_rx != crc_r[c])
      status_nxt = `CFP_ST_HCRC_BAD;
    else if (rev_r[c] != `CFP_FRAME_REV || !cmd_known)
      status_nxt = `CFP_ST_UNKNOWN;
    else if ((cmd_r[c] == `CFP_CMD_READ || cmd_r[c] == `CFP_CMD_WRITE) &&
             len_r[c][31:1] == 31'h00000000)
      status_nxt = `CFP_ST_LEN_ZERO;
    else
      status_nxt = `CFP_ST_OK;
  end

  // ------------------------------------------------------------
  // One response per header.
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resp_valid_r <= 1'b0;
      resp_r       <= '0;
    end
    else if (!rst_n_r)
      resp_valid_r <= 1'b0;
    else if (hdr_done)
    begin
      resp_valid_r           <= 1'b1;
      resp_r.conn            <= c;
      resp_r.status          <= status_nxt;
      resp_r.opcode          <= cmd_r[c];
      resp_r.first_reg_index <= addr_r[c];
      resp_r.reg_count       <= len_r[c][31:1];
    end
    else if (resp_ready)
      resp_valid_r <= 1'b0;
  end

  assign resp_valid = resp_valid_r;
  assign resp       = resp_r;

  // ------------------------------------------------------------
  // Restart and network settings commit.
  // ------------------------------------------------------------
  logic        resp_ok;
  logic [31:0] last_idx;

  assign resp_ok  = resp_valid_r && resp_ready && (resp_r.status == `CFP_ST_OK);
  assign last_idx = 32'(resp_r.first_reg_index) + 32'(resp_r.reg_count) - 32'h00000001;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      restart_r <= 1'b0;
      apply_r   <= 1'b0;
    end
    else
    begin
      restart_r <= resp_ok && (resp_r.opcode == `CFP_CMD_RESET);
      apply_r   <= resp_ok && (resp_r.opcode == `CFP_CMD_WRITE) &&
                   (resp_r.first_reg_index <= GATEWAY_IDX) &&
                   (32'(GATEWAY_IDX) <= last_idx);
    end
  end

  assign dev_restart   = restart_r;
  assign net_cfg_apply = apply_r;

  // ------------------------------------------------------------
  // Connection slots and idle timers.
  // ------------------------------------------------------------
  generate
    for (genvar g = 0; g < NUM_CONN; g++)
    begin : g_conn
      logic [31:0] idle_r;

      assign timeout[g] = open_r[g] && (idle_r >= IDLE_CYCLES - 32'h00000001);

      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          open_r[g]  <= 1'b0;
          idle_r     <= 32'h00000000;
          close_r[g] <= 1'b0;
        end
        else if (!rst_n_r)
        begin
          open_r[g]  <= 1'b0;
          close_r[g] <= 1'b0;
        end
        else
        begin
          close_r[g] <= timeout[g] && !conn_open[g];
          if (conn_open[g])
          begin
            open_r[g] <= 1'b1;
            idle_r    <= 32'h00000000;
          end
          else if (timeout[g])
          begin
            open_r[g] <= 1'b0;
            idle_r    <= 32'h00000000;
          end
          else if (hdr_done && 32'(c) == g)
            idle_r <= 32'h00000000;
          else if (open_r[g])
            idle_r <= idle_r + 32'h00000001;
        end
      end
    end
  endgenerate

  assign conn_close  = close_r;
  assign conn_active = open_r;

endmodule

// ==== verif/cfp_parser_asserts.sv ====
// Concurrent checks on the control frame parser ports.
`timescale 1ns/1ps
`include "cfp_regs.svh"
module cfp_parser_asserts
  import cfp_pkg::*;
#(
  parameter int          NUM_CONN    = `CFP_NUM_CONN,
  parameter logic [31:0] IDLE_CYCLES = 32'h000000C8
)
(
  input wire logic                clock,
  input wire logic                rst_b,
  input wire logic [NUM_CONN-1:0] conn_open,
  input wire logic [NUM_CONN-1:0] conn_close,
  input wire logic [NUM_CONN-1:0] conn_active,
  input wire logic                rx_valid,
  input wire logic                rx_ready,
  input wire cfp_rx_byte_t        rx_byte,
  input wire logic                resp_valid,
  input wire logic                resp_ready,
  input wire cfp_resp_t           resp,
  input wire logic                dev_restart,
  input wire logic                net_cfg_apply
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_NO_RX_IN_RESP: assert property (resp_valid |-> !rx_ready)
    else $error("rx_ready high while response pending");
  AST_RESP_HOLD: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp))
    else $error("response dropped or changed");
  AST_RESP_ONCE: assert property (resp_valid && resp_ready |=> !resp_valid)
    else $error("response repeated");
  AST_RESP_AFTER_BYTE: assert property ($rose(resp_valid) |-> $past(rx_valid && rx_ready))
    else $error("response without final byte");
  AST_STATUS_CODE: assert property (resp_valid |-> resp.status inside
    {`CFP_ST_OK, `CFP_ST_HCRC_BAD, `CFP_ST_LEN_ZERO, `CFP_ST_UNKNOWN})
    else $error("bad status code");
  AST_READ_COUNT: assert property (resp_valid && resp.status == `CFP_ST_OK
    && resp.opcode == `CFP_CMD_READ |-> resp.reg_count != 0)
    else $error("read with no registers");
  AST_RESTART: assert property (dev_restart |-> $past(resp_valid && resp_ready
    && resp.opcode == `CFP_CMD_RESET && resp.status == `CFP_ST_OK))
    else $error("restart without reset response");
  AST_NET_APPLY: assert property (net_cfg_apply |-> $past(resp_valid && resp_ready
    && resp.opcode == `CFP_CMD_WRITE && resp.status == `CFP_ST_OK))
    else $error("apply without write response");
  AST_OPEN_ACTIVE: assert property (|conn_open |=>
    (conn_active & $past(conn_open)) == $past(conn_open))
    else $error("opened slot not active");
  AST_CLOSE_PULSE: assert property (|conn_close |=> (conn_close & $past(conn_close)) == '0)
    else $error("close pulse too long");
endmodule

// ==== verif/cfp_host_model.sv ====
// Host model that sends command headers and takes responses.
`timescale 1ns/1ps
`include "cfp_regs.svh"
module cfp_host_model
  import cfp_pkg::*;
(
  input  wire logic    clock,
  input  wire logic    rx_ready,
  input  wire logic    resp_valid,
  output logic         rx_valid,
  output cfp_rx_byte_t rx_byte,
  output logic         resp_ready
);
  // ----------------------------------------
  // Header sender
  // ----------------------------------------
  bit         slow = 0;
  logic [7:0] b [64];
  initial
  begin
    rx_valid = 1'b0;
    rx_byte = '0;
    resp_ready = 1'b0;
  end
  always @(negedge clock)
    resp_ready <= slow ? 1'($urandom % 3 == 0) : 1'b1;
  task automatic send(input logic [2:0] c, input logic [7:0] rev, input logic [7:0] cmd,
                      input logic [31:0] len, input logic [15:0] idx, input bit bad);
    logic [15:0] crc;
    crc = `CFP_CRC_INIT;
    foreach (b[i]) b[i] = 8'($urandom);
    {b[0], b[1], b[2], b[3]} = {`CFP_SYNC_HI, `CFP_SYNC_LO, rev, cmd};
    {b[8], b[9], b[10], b[11], b[12], b[13]} = {len[31:1], 1'b0, idx};
    {b[58], b[59], b[60], b[61]} = 32'h00000000;
    for (int i = 2; i < 62; i++)
    begin
      crc = crc ^ {b[i], 8'h00};
      repeat (8) crc = crc[15] ? ((crc << 1) ^ `CFP_CRC_POLY) : (crc << 1);
    end
    {b[62], b[63]} = crc ^ {15'h0000, bad};
    @(negedge clock);
    for (int i = -1; i < 64; i++)
    begin
      while (!rx_ready) @(negedge clock);
      rx_valid = 1'b1;
      rx_byte = '{conn: c, data: (i < 0) ? 8'h33 : b[i]};
      @(negedge clock);
    end
    rx_valid = 1'b0;
    rx_byte.data = ~rx_byte.data;
  endtask
endmodule

// ==== verif/testbench.sv ====
// Top testbench of the control frame parser with host model and reference queues.
`timescale 1ns/1ps
`include "cfp_regs.svh"
module testbench
  import cfp_pkg::*;
;
  // ----------------------------------------
  // Stimulus and reference
  // ----------------------------------------
  localparam logic [31:0] IDLE = 32'h00000FA0;
  logic         clock = 0, rst_b = 0, rx_valid, rx_ready, resp_valid, resp_ready;
  logic         dev_restart, net_cfg_apply;
  logic [4:0]   conn_open = '0, conn_close, conn_active;
  cfp_rx_byte_t rx_byte;
  cfp_resp_t    resp;
  int           err_count = 0, tests_run = 0, cyc = 0, n, n_rst = 0, n_app = 0, e_rst = 0, e_app = 0;
  logic [18:0]  top_q [$];
  logic [47:0]  fld_q [$];
  logic [47:0]  fq;
  logic [7:0]   ops [5] = '{8'h03, 8'h04, 8'h05, 8'h0A, 8'h07};
  initial forever #10 clock = ~clock;
  cfp_parser #(.IDLE_CYCLES(IDLE)) dut_u (.clock(clock), .rst_b(rst_b), .conn_open(conn_open),
    .conn_close(conn_close), .conn_active(conn_active), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .resp_valid(resp_valid), .resp_ready(resp_ready),
    .resp(resp), .dev_restart(dev_restart), .net_cfg_apply(net_cfg_apply));
  cfp_host_model host_u (.clock(clock), .rx_ready(rx_ready), .resp_valid(resp_valid),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .resp_ready(resp_ready));
  task automatic check(input string nm, input logic [65:0] seen, input logic [65:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic open(input logic [4:0] m);
    @(negedge clock);
    conn_open = m;
    @(negedge clock);
    conn_open = '0;
  endtask
  task automatic frame(input logic [2:0] c, input logic [7:0] rev, input logic [7:0] cmd,
                       input logic [31:0] len, input logic [15:0] idx, input bit bad, input bit live);
    logic [7:0] st;
    longint     cnt;
    cnt = len >> 1;
    st = bad ? `CFP_ST_HCRC_BAD : (rev != `CFP_FRAME_REV || !(cmd inside {8'h03, 8'h04, 8'h05,
      8'h0A})) ? `CFP_ST_UNKNOWN : (cmd inside {8'h03, 8'h04} && cnt == 0) ? `CFP_ST_LEN_ZERO
      : `CFP_ST_OK;
    if (live)
    begin
      top_q.push_back({c, st, cmd});
      fld_q.push_back({st == `CFP_ST_OK || st == `CFP_ST_LEN_ZERO, idx, len[31:1]});
      e_rst += (st == `CFP_ST_OK && cmd == `CFP_CMD_RESET);
      e_app += (st == `CFP_ST_OK && cmd == `CFP_CMD_WRITE && idx <= `CFP_GATEWAY_IDX
        && idx + cnt - 1 >= `CFP_GATEWAY_IDX);
    end
    host_u.send(c, rev, cmd, len, idx, bad);
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 15000)
    begin
      err_count++;
      tally_and_finish();
    end
    n_rst += dev_restart;
    n_app += net_cfg_apply;
    if (rst_b && resp_valid && resp_ready)
    begin
      if (top_q.size() == 0) check("unexpected response", 1, 0);
      else
      begin
        check("response head", {resp.conn, resp.status, resp.opcode}, top_q.pop_front());
        fq = fld_q.pop_front();
        if (fq[47]) check("response fields", {resp.first_reg_index, resp.reg_count}, fq[46:0]);
      end
    end
  end
  initial
  begin
    void'($urandom(98198));
    repeat (6) @(negedge clock);
    rst_b = 1'b1;
    repeat (3) @(negedge clock);
    check("rx_ready after reset", rx_ready, 1);
    open(5'h1F);
    foreach (ops[k]) frame(3'(k), 8'h03, ops[k], 32'(2 * ($urandom % 40) + 2), 16'($urandom), 0, 1);
    frame(0, 8'h02, 8'h03, 4, 16'h0000, 0, 1);
    frame(1, 8'h03, 8'h03, 8, 16'h1234, 1, 1);
    frame(2, 8'h03, 8'h03, 0, 16'h0005, 0, 1);
    frame(3, 8'h03, 8'h03, 6, 16'hFFFF, 0, 1);
    host_u.slow = 1;
    frame(4, 8'h03, 8'h04, 4, 16'h00FF, 0, 1);
    frame(0, 8'h03, 8'h04, 2, 16'h0101, 0, 1);
    frame(1, 8'h03, 8'h05, 0, 16'h0000, 0, 1);
    host_u.slow = 0;
    repeat (20) frame(3'($urandom % 5), 8'h03, 8'h03, 32'(2 * ($urandom % 100)), 16'($urandom), 0, 1);
    open(5'h10);
    n = 0;
    while (!conn_close[4] && n < 5000)
    begin
      @(negedge clock);
      n++;
    end
    check("idle close time", n >= IDLE - 1 && n <= IDLE + 3, 1);
    check("slot closed", conn_active[4], 0);
    frame(4, 8'h03, 8'h03, 2, 16'h0001, 0, 0);
    open(5'h1F);
    frame(4, 8'h03, 8'h03, 2, 16'h0042, 0, 1);
    repeat (10) @(negedge clock);
    check("pending responses", top_q.size(), 0);
    check("restart pulses", n_rst, e_rst);
    check("apply pulses", n_app, e_app);
    tally_and_finish();
  end
endmodule
bind cfp_parser cfp_parser_asserts #(.NUM_CONN(NUM_CONN), .IDLE_CYCLES(IDLE_CYCLES)) chk_u (
  .clock(clock), .rst_b(rst_b), .conn_open(conn_open), .conn_close(conn_close),
  .conn_active(conn_active), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte),
  .resp_valid(resp_valid), .resp_ready(resp_ready), .resp(resp), .dev_restart(dev_restart),
  .net_cfg_apply(net_cfg_apply));
